// >>> cell_master.sv
// link side master model: makes both transfer clocks, polls, sends and takes cells
`timescale 1ns/1ns
module cell_master (
    // system clock
    input wire clk,
    // transmit pins
    output reg tx_clk,
    output reg tx_enb_n,
    output reg tx_soc,
    output reg [7:0] tx_data,
    output reg [4:0] tx_addr,
    input wire tx_clav,
    // receive pins
    output reg rx_clk,
    output reg rx_enb_n,
    output reg [4:0] rx_addr,
    input wire [7:0] rx_data,
    input wire rx_soc,
    input wire rx_clav
);
    reg s_tx_clav, s_rx_clav, s_rx_soc;
    reg [7:0] s_rx_data;
    initial begin
        tx_clk = 1'b1;
        rx_clk = 1'b1;
        tx_enb_n = 1'b1;
        tx_soc = 1'b0;
        tx_data = 8'h00;
        tx_addr = 5'h1F;
        rx_enb_n = 1'b1;
        rx_addr = 5'h1F;
    end
    // one 160 ns transmit cycle; the clock stands still between calls
    task tcyc(input reg enb_n, input reg soc, input reg [7:0] d, input reg [4:0] a);
        begin
            @(posedge clk);
            tx_clk <= 1'b0;
            tx_enb_n <= enb_n;
            tx_soc <= soc;
            tx_data <= enb_n ? ~tx_data : d; // idle bus toggles so no stale byte looks valid
            tx_addr <= a;
            repeat (10) @(posedge clk);
            tx_clk <= 1'b1;
            s_tx_clav <= tx_clav;
            repeat (9) @(posedge clk);
        end
    endtask
    // one receive cycle; what is sampled answers the previous cycle's enable
    task rcyc(input reg enb_n, input reg [4:0] a);
        begin
            @(posedge clk);
            rx_clk <= 1'b0;
            rx_enb_n <= enb_n;
            rx_addr <= a;
            repeat (10) @(posedge clk);
            rx_clk <= 1'b1;
            s_rx_clav <= rx_clav;
            s_rx_data <= rx_data;
            s_rx_soc <= rx_soc;
            repeat (9) @(posedge clk);
        end
    endtask
endmodule

// >>> cell_port_props.sv
// assertions on the outputs of the phy side cell port
`timescale 1ns/1ns
module cell_port_props #(parameter OFFICE_SIDE = 1) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // link flags
    input wire tx_clav,
    input wire tx_clav_oe,
    input wire rx_clav,
    input wire rx_clav_oe,
    input wire rx_soc,
    input wire rx_data_oe,
    // transceiver side
    input wire tx_cell_valid,
    input wire tx_cell_soc,
    input wire tx_cell_last,
    input wire rx_cell_valid,
    input wire rx_cell_path,
    input wire [1:0] rx_cell_ready,
    // timing reference
    input wire tx_ref_n,
    input wire rx_ref_n,
    input wire net_ref_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_byte; tx_cell_valid; endsequence
    sequence s_gap; !tx_cell_valid [*2]; endsequence
    property p_byte_gap; s_byte |=> s_gap; endproperty
    a_byte_gap: assert property (p_byte_gap) else $error("byte strobe too long");
    property p_soc; tx_cell_soc |-> s_byte; endproperty
    a_soc: assert property (p_soc) else $error("start flag without byte");
    property p_last; tx_cell_last |-> s_byte and !tx_cell_soc; endproperty
    a_last: assert property (p_last) else $error("last flag misplaced");
    property p_tx_clav_oe; tx_clav |-> tx_clav_oe; endproperty
    a_tx_clav_oe: assert property (p_tx_clav_oe) else $error("tx flag while unselected");
    property p_rx_clav_oe; rx_clav |-> rx_clav_oe; endproperty
    a_rx_clav_oe: assert property (p_rx_clav_oe) else $error("rx flag while unselected");
    property p_rx_soc_oe; rx_soc |-> rx_data_oe; endproperty
    a_rx_soc_oe: assert property (p_rx_soc_oe) else $error("rx start while released");
    property p_ref_out; OFFICE_SIDE != 0 |-> rx_ref_n; endproperty
    a_ref_out: assert property (p_ref_out) else $error("reference out driven");
    property p_ref_in; OFFICE_SIDE != 0 && $fell(tx_ref_n) |-> ##[1:4] !net_ref_n; endproperty
    a_ref_in: assert property (p_ref_in) else $error("reference not passed on");
    property p_full; $fell(rx_cell_ready[0]) |-> $past(rx_cell_valid) && !$past(rx_cell_path);
    endproperty
    a_full: assert property (p_full) else $error("store full without a write");
endmodule
bind utopia_l2_phy_cell_port cell_port_props #(.OFFICE_SIDE(OFFICE_SIDE)) i_cell_port_props (
    .clk(clk), .rst_n(rst_n), .tx_clav(tx_clav), .tx_clav_oe(tx_clav_oe), .rx_clav(rx_clav),
    .rx_clav_oe(rx_clav_oe), .rx_soc(rx_soc), .rx_data_oe(rx_data_oe),
    .tx_cell_valid(tx_cell_valid), .tx_cell_soc(tx_cell_soc), .tx_cell_last(tx_cell_last),
    .rx_cell_valid(rx_cell_valid), .rx_cell_path(rx_cell_path), .rx_cell_ready(rx_cell_ready),
    .tx_ref_n(tx_ref_n), .rx_ref_n(rx_ref_n), .net_ref_n(net_ref_n)
);

// >>> tb_top.sv
// self-checking bench of the phy side cell port
`timescale 1ns/1ns
module tb_top;
    reg clk, rst_n, tx_ref_n, tc_ref_n, rx_cell_valid, rx_cell_path;
    reg [1:0] tx_room;
    reg [7:0] rx_cell_data;
    wire tx_clk, tx_enb_n, tx_soc, tx_clav, tx_clav_oe, rx_clk, rx_enb_n, rx_data_oe, rx_soc;
    wire rx_clav, rx_clav_oe, rx_ref_n, tx_cell_valid, tx_cell_soc, tx_cell_last, tx_cell_path;
    wire net_ref_n;
    wire [7:0] tx_data, rx_data, tx_cell_data;
    wire [4:0] tx_addr, rx_addr;
    wire [1:0] rx_cell_ready;
    // released flags read low; a released data bus shows the inverse of its last byte
    wire tx_clav_pin = tx_clav_oe ? tx_clav : 1'b0;
    wire rx_clav_pin = rx_clav_oe ? rx_clav : 1'b0;
    wire [7:0] rx_data_pin = rx_data_oe ? rx_data : ~rx_data;
    integer errors, samples_checked, nval, i;
    reg [7:0] got_d [0:63];
    reg [2:0] got_f [0:63];
    utopia_l2_phy_cell_port i_utopia_l2_phy_cell_port (.clk(clk), .rst_n(rst_n),
        .tx_clk(tx_clk), .tx_enb_n(tx_enb_n), .tx_soc(tx_soc), .tx_data(tx_data),
        .tx_addr(tx_addr), .tx_clav(tx_clav), .tx_clav_oe(tx_clav_oe), .rx_clk(rx_clk),
        .rx_enb_n(rx_enb_n), .rx_addr(rx_addr), .rx_data(rx_data), .rx_data_oe(rx_data_oe),
        .rx_soc(rx_soc), .rx_clav(rx_clav), .rx_clav_oe(rx_clav_oe), .tx_ref_n(tx_ref_n),
        .rx_ref_n(rx_ref_n), .tx_room(tx_room), .tx_cell_data(tx_cell_data),
        .tx_cell_valid(tx_cell_valid), .tx_cell_soc(tx_cell_soc), .tx_cell_last(tx_cell_last),
        .tx_cell_path(tx_cell_path), .rx_cell_data(rx_cell_data),
        .rx_cell_valid(rx_cell_valid), .rx_cell_path(rx_cell_path),
        .rx_cell_ready(rx_cell_ready), .tc_ref_n(tc_ref_n), .net_ref_n(net_ref_n));
    cell_master i_cell_master (.clk(clk), .tx_clk(tx_clk), .tx_enb_n(tx_enb_n),
        .tx_soc(tx_soc), .tx_data(tx_data), .tx_addr(tx_addr), .tx_clav(tx_clav_pin),
        .rx_clk(rx_clk), .rx_enb_n(rx_enb_n), .rx_addr(rx_addr), .rx_data(rx_data_pin),
        .rx_soc(rx_soc), .rx_clav(rx_clav_pin));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (tx_cell_valid === 1'b1 && nval < 64) begin
            got_d[nval] = tx_cell_data;
            got_f[nval] = {tx_cell_soc, tx_cell_last, tx_cell_path};
            nval = nval + 1;
        end
    end
    function [7:0] pat(input integer p, input integer k);
        pat = 8'h40 + k[7:0] + (p != 0 ? 8'h80 : 8'h00);
    endfunction
    task check(input reg [7:0] g, input reg [7:0] e, input [8*16-1:0] m);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("BAD %0t %0s got %h exp %h", $time, m, g, e);
            end
        end
    endtask
    task t_ref;
        begin
            @(posedge clk) tx_ref_n <= 1'b0;
            tc_ref_n <= 1'b0;
            repeat (6) @(posedge clk);
            check({7'h00, net_ref_n}, 8'h00, "ref in");
            check({7'h00, rx_ref_n}, 8'h01, "ref out");
            tx_ref_n <= 1'b1;
            tc_ref_n <= 1'b1;
        end
    endtask
    task t_tx_cell(input integer p);
        reg [4:0] a;
        begin
            a = p != 0 ? 5'h01 : 5'h00;
            @(posedge clk) tx_room <= p != 0 ? 2'b10 : 2'b01;
            i_cell_master.tcyc(1'b1, 1'b0, 8'h00, a);
            check({7'h00, tx_clav_oe}, 8'h01, "tx select");
            nval = 0;
            i_cell_master.tcyc(1'b0, 1'b0, 8'h5A, a);
            check(nval[7:0], 8'h00, "orphan byte");
            for (i = 0; i < 53; i = i + 1) begin
                i_cell_master.tcyc(1'b0, i == 0, pat(p, i), a);
                check({7'h00, i_cell_master.s_tx_clav}, {7'h00, i < 49}, "tx space");
            end
            @(posedge clk) tx_room <= 2'b00;
            check(nval[7:0], 8'h35, "tx byte count");
            for (i = 0; i < 53; i = i + 1) begin
                check(got_d[i], pat(p, i), "tx byte");
                check({5'h00, got_f[i]}, {5'h00, i == 0, i == 52, p[0]}, "tx flags");
            end
            i_cell_master.tcyc(1'b1, 1'b0, 8'h00, a);
            i_cell_master.tcyc(1'b1, 1'b0, 8'h00, a);
            check({7'h00, i_cell_master.s_tx_clav}, 8'h00, "tx full");
            i_cell_master.tcyc(1'b1, 1'b0, 8'h00, 5'h07);
            check({7'h00, tx_clav_oe}, 8'h00, "tx unselected");
        end
    endtask
    task t_rx_cell(input integer p);
        reg [4:0] a;
        begin
            a = p != 0 ? 5'h01 : 5'h00;
            for (i = 0; i < 53; i = i + 1) begin
                @(posedge clk);
                rx_cell_valid <= 1'b1;
                rx_cell_path <= p[0];
                rx_cell_data <= pat(p, i);
            end
            @(posedge clk) rx_cell_valid <= 1'b0;
            @(posedge clk);
            check({6'h00, rx_cell_ready}, p != 0 ? 8'h01 : 8'h02, "store full");
            i_cell_master.rcyc(1'b1, a);
            for (i = 0; i < 54; i = i + 1) begin
                i_cell_master.rcyc(i == 53, a);
                if (i == 0) begin
                    check({7'h00, i_cell_master.s_rx_clav}, 8'h01, "rx cell flag");
                end else begin
                    check(i_cell_master.s_rx_data, pat(p, i - 1), "rx byte");
                    check({7'h00, i_cell_master.s_rx_soc}, {7'h00, i == 1}, "rx start");
                end
            end
            i_cell_master.rcyc(1'b1, a);
            i_cell_master.rcyc(1'b1, a);
            check({7'h00, i_cell_master.s_rx_clav}, 8'h00, "rx flag low");
            check({6'h00, rx_cell_ready}, 8'h03, "store empty");
            i_cell_master.rcyc(1'b1, 5'h07);
            check({6'h00, rx_clav_oe, rx_data_oe}, 8'h00, "rx unselected");
        end
    endtask
    task tally_and_finish;
        begin
            $display("errors %0d samples_checked %0d", errors, samples_checked);
            if (errors == 0 && samples_checked > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        errors = errors + 1;
        tally_and_finish;
    end
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        tx_ref_n = 1'b1;
        tc_ref_n = 1'b1;
        tx_room = 2'b00;
        rx_cell_valid = 1'b0;
        rx_cell_path = 1'b0;
        rx_cell_data = 8'h00;
        errors = 0;
        samples_checked = 0;
        nval = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_ref;
        t_tx_cell(0);
        t_tx_cell(1);
        t_rx_cell(0);
        t_rx_cell(1);
        tally_and_finish;
    end
endmodule

// >>> utopia_cell_port_map.vh
// constants of the cell transfer port: cell geometry, flow control lead, port addresses
`ifndef UTOPIA_CELL_PORT_MAP_VH
`define UTOPIA_CELL_PORT_MAP_VH

// ****************************************
// cell geometry
// ****************************************
`define CELL_BYTES 53
`define CELL_CNT_W 6
`define BYTE_W 8

// ****************************************
// flow control
// ****************************************
// tx space flag falls this many transfer cycles before the last byte
`define TX_CLAV_LEAD 4

// ****************************************
// addressing
// ****************************************
`define ADDR_W 5
`define FAST_PORT_ADDR 5'h00
`define SLOW_PORT_ADDR 5'h01

// ****************************************
// path numbering
// ****************************************
`define PATH_FAST 0
`define PATH_SLOW 1
`define NUM_PATHS 2

// ****************************************
// synchroniser vector layout
// ****************************************
`define TX_PIN_W 17
`define RX_PIN_W 7

`endif

// >>> utopia_l2_phy_cell_port.v
// phy side of the 8-bit cell level handshake port, one addressable port per latency path
`timescale 1ns/1ns
`include "utopia_cell_port_map.vh"

module utopia_l2_phy_cell_port #(
    parameter OFFICE_SIDE = 1,
    parameter [`ADDR_W-1:0] FAST_ADDR = `FAST_PORT_ADDR,
    parameter [`ADDR_W-1:0] SLOW_ADDR = `SLOW_PORT_ADDR
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // link transmit pins
    input wire tx_clk,
    input wire tx_enb_n,
    input wire tx_soc,
    input wire [`BYTE_W-1:0] tx_data,
    input wire [`ADDR_W-1:0] tx_addr,
    output reg tx_clav,
    output reg tx_clav_oe,
    // link receive pins
    input wire rx_clk,
    input wire rx_enb_n,
    input wire [`ADDR_W-1:0] rx_addr,
    output reg [`BYTE_W-1:0] rx_data,
    output reg rx_data_oe,
    output reg rx_soc,
    output reg rx_clav,
    output reg rx_clav_oe,
    // network timing reference pins
    input wire tx_ref_n,
    output reg rx_ref_n,
    // transceiver side: cells taken from the link
    input wire [`NUM_PATHS-1:0] tx_room,
    output reg [`BYTE_W-1:0] tx_cell_data,
    output reg tx_cell_valid,
    output reg tx_cell_soc,
    output reg tx_cell_last,
    output reg tx_cell_path,
    // transceiver side: cells handed to the link
    input wire [`BYTE_W-1:0] rx_cell_data,
    input wire rx_cell_valid,
    input wire rx_cell_path,
    output wire [`NUM_PATHS-1:0] rx_cell_ready,
    // transceiver side: timing reference
    input wire tc_ref_n,
    output reg net_ref_n
);

    // ****************************************
    // helpers
    // ****************************************
    // one-hot path hit for an address on either bus
    function [`NUM_PATHS-1:0] port_hit;
        input [`ADDR_W-1:0] addr;
        begin
            port_hit = {addr == SLOW_ADDR, addr == FAST_ADDR};
        end
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    // data, strobes and clock go through the same two stages, so they stay aligned
    reg [`TX_PIN_W-1:0] tx_s1;
    reg [`TX_PIN_W-1:0] tx_s2;
    reg [`RX_PIN_W-1:0] rx_s1;
    reg [`RX_PIN_W-1:0] rx_s2;
    reg tx_clk_d;
    reg rx_clk_d;
    // the master parks its transfer clocks high, so the stages and the edge history
    // start high as well: a low start would show a false transfer edge after reset
    // limitation: each transfer clock phase must last at least three system clocks
    localparam [`TX_PIN_W-1:0] TX_PIN_IDLE = {1'b1, {`TX_PIN_W-4{1'b0}}, 3'h3};
    localparam [`RX_PIN_W-1:0] RX_PIN_IDLE = {{`RX_PIN_W-2{1'b0}}, 2'h3};

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_s1 <= TX_PIN_IDLE;
            tx_s2 <= TX_PIN_IDLE;
            rx_s1 <= RX_PIN_IDLE;
            rx_s2 <= RX_PIN_IDLE;
            tx_clk_d <= 1'b1;
            rx_clk_d <= 1'b1;
        end else begin
            tx_s1 <= {tx_ref_n, tx_addr, tx_data, tx_soc, tx_enb_n, tx_clk};
            tx_s2 <= tx_s1;
            rx_s1 <= {rx_addr, rx_enb_n, rx_clk};
            rx_s2 <= rx_s1;
            tx_clk_d <= tx_s2[0];
            rx_clk_d <= rx_s2[0];
        end
    end

    wire tx_edge;
    wire tx_enb_s_n;
    wire tx_soc_s;
    wire [`BYTE_W-1:0] tx_data_s;
    wire [`ADDR_W-1:0] tx_addr_s;
    wire tx_ref_s_n;
    wire rx_edge;
    wire rx_enb_s_n;
    wire [`ADDR_W-1:0] rx_addr_s;

    assign tx_edge = tx_s2[0] && !tx_clk_d;
    assign tx_enb_s_n = tx_s2[1];
    assign tx_soc_s = tx_s2[2];
    assign tx_data_s = tx_s2[10:3];
    assign tx_addr_s = tx_s2[15:11];
    assign tx_ref_s_n = tx_s2[16];
    assign rx_edge = rx_s2[0] && !rx_clk_d;
    assign rx_enb_s_n = rx_s2[1];
    assign rx_addr_s = rx_s2[6:2];

    // ****************************************
    // transmit direction
    // ****************************************
    reg [`NUM_PATHS-1:0] tx_sel;
    reg [`NUM_PATHS-1:0] tx_busy;
    reg [`CELL_CNT_W-1:0] tx_cnt;
    wire [`NUM_PATHS-1:0] tx_hit;
    wire [`NUM_PATHS-1:0] tx_space;
    wire tx_late;
    wire tx_cont;
    wire tx_take;
    wire [`CELL_CNT_W-1:0] tx_cnt_ahead;
    // space flag falls once this many bytes of the cell are in
    localparam TX_LATE_AT = `CELL_BYTES - `TX_CLAV_LEAD;

    assign tx_hit = port_hit(tx_addr_s);
    // a byte is taken with enable low on a selected port that starts or continues a cell
    assign tx_cont = |(tx_busy & tx_sel);
    assign tx_take = !tx_enb_s_n && |tx_sel && (tx_soc_s || tx_cont);
    // count as it stands after this edge, so the lead is kept even with no pause
    assign tx_cnt_ahead = tx_cnt + {{`CELL_CNT_W-1{1'b0}}, tx_take & ~tx_soc_s};
    // once the cell is within the lead of its end, its path stops offering space
    assign tx_late = (tx_cnt_ahead >= TX_LATE_AT);
    assign tx_space = tx_room & ~(tx_busy & {`NUM_PATHS{tx_late}});

    // polling answer only for our own two addresses
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_clav <= 1'b0;
            tx_clav_oe <= 1'b0;
        end else if (tx_edge) begin
            tx_clav_oe <= |tx_hit;
            tx_clav <= |(tx_hit & tx_space);
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_sel <= {`NUM_PATHS{1'b0}};
            tx_busy <= {`NUM_PATHS{1'b0}};
            tx_cnt <= {`CELL_CNT_W{1'b0}};
            tx_cell_data <= {`BYTE_W{1'b0}};
            tx_cell_valid <= 1'b0;
            tx_cell_soc <= 1'b0;
            tx_cell_last <= 1'b0;
            tx_cell_path <= 1'b0;
        end else begin
            tx_cell_valid <= 1'b0;
            tx_cell_soc <= 1'b0;
            tx_cell_last <= 1'b0;
            if (tx_edge) begin
                if (tx_enb_s_n) begin
                    // selection is latched while enable is still high
                    tx_sel <= tx_hit;
                end else if (|tx_sel) begin
                    // a byte that is neither a cell start nor inside a cell is dropped
                    if (tx_take) begin
                        tx_cell_valid <= 1'b1;
                        tx_cell_data <= tx_data_s;
                        tx_cell_soc <= tx_soc_s;
                        tx_cell_path <= tx_sel[`PATH_SLOW];
                        if (tx_soc_s) begin
                            tx_cnt <= {{`CELL_CNT_W-1{1'b0}}, 1'b1};
                            tx_busy <= tx_sel;
                        end else if (tx_cnt == `CELL_BYTES - 1) begin
                            tx_cnt <= {`CELL_CNT_W{1'b0}};
                            tx_busy <= {`NUM_PATHS{1'b0}};
                            tx_cell_last <= 1'b1;
                        end else begin
                            tx_cnt <= tx_cnt + 1'b1;
                        end
                    end
                end
            end
        end
    end

    // ****************************************
    // receive direction
    // ****************************************
    reg [`NUM_PATHS-1:0] rx_sel;
    wire [`NUM_PATHS-1:0] rx_hit;
    wire [`NUM_PATHS-1:0] rx_full;
    wire [`NUM_PATHS-1:0] rx_first;
    wire [`NUM_PATHS-1:0] rx_take;
    wire [`BYTE_W-1:0] rx_byte [0:`NUM_PATHS-1];
    wire rx_go;
    reg [`BYTE_W-1:0] next_rx_byte;
    reg next_rx_first;

    assign rx_hit = port_hit(rx_addr_s);
    // a byte is handed out only while a complete cell is held on the selected path
    assign rx_go = rx_edge && !rx_enb_s_n;
    assign rx_take = rx_sel & rx_full & {`NUM_PATHS{rx_go}};

    // head byte of the path being drained; one address never selects both paths
    always @* begin
        next_rx_byte = rx_byte[`PATH_FAST];
        next_rx_first = rx_first[`PATH_FAST];
        if (rx_take[`PATH_SLOW]) begin
            next_rx_byte = rx_byte[`PATH_SLOW];
            next_rx_first = rx_first[`PATH_SLOW];
        end
    end

    genvar p;
    generate
        for (p = 0; p < `NUM_PATHS; p = p + 1) begin : g_path
            utopia_rx_cell_store #(
                .WIDTH(`BYTE_W),
                .DEPTH(`CELL_BYTES)
            ) u_store (
                .clk(clk),
                .rst_n(rst_n),
                .wr_valid(rx_cell_valid && (rx_cell_path == p)),
                .wr_data(rx_cell_data),
                .wr_ready(rx_cell_ready[p]),
                .rd_take(rx_take[p]),
                .rd_data(rx_byte[p]),
                .rd_first(rx_first[p]),
                .full(rx_full[p])
            );
        end
    endgenerate

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sel <= {`NUM_PATHS{1'b0}};
            rx_data <= {`BYTE_W{1'b0}};
            rx_data_oe <= 1'b0;
            rx_soc <= 1'b0;
            rx_clav <= 1'b0;
            rx_clav_oe <= 1'b0;
        end else if (rx_edge) begin
            rx_clav_oe <= |rx_hit;
            // the store empties on the last byte, so the flag falls one transfer edge after the cell end
            rx_clav <= |(rx_hit & rx_full);
            if (rx_enb_s_n) begin
                rx_sel <= rx_hit;
                rx_data_oe <= |rx_hit;
                rx_soc <= 1'b0;
            end else if (|rx_take) begin
                // presented now, sampled by the master on its next transfer edge
                rx_data <= next_rx_byte;
                rx_soc <= next_rx_first;
            end else begin
                // nothing held: the bus keeps its last byte, no cell start shown
                rx_soc <= 1'b0;
            end
        end
    end

    // ****************************************
    // network timing reference
    // ****************************************
    // office side passes the master's reference inward; remote side drives it out
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            net_ref_n <= 1'b1;
        end else begin
            net_ref_n <= (OFFICE_SIDE != 0) ? tx_ref_s_n : 1'b1;
        end
    end

    // the unused direction idles inactive so a shared pin never sees a stray pulse
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_ref_n <= 1'b1;
        end else begin
            rx_ref_n <= (OFFICE_SIDE != 0) ? 1'b1 : tc_ref_n;
        end
    end

endmodule

// >>> utopia_rx_cell_store.v
// one-cell receive store: filled by the transceiver side, drained by the link side
`timescale 1ns/1ns
`include "utopia_cell_port_map.vh"

module utopia_rx_cell_store #(
    parameter WIDTH = `BYTE_W,
    parameter DEPTH = `CELL_BYTES
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // fill side
    input wire wr_valid,
    input wire [WIDTH-1:0] wr_data,
    output reg wr_ready,
    // drain side
    input wire rd_take,
    output wire [WIDTH-1:0] rd_data,
    output wire rd_first,
    output reg full
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [`CELL_CNT_W-1:0] wr_idx;
    reg [`CELL_CNT_W-1:0] rd_idx;
    wire wr_fire;
    wire rd_fire;

    assign wr_fire = wr_valid && wr_ready;
    assign rd_fire = rd_take && full;
    assign rd_data = mem[rd_idx];
    assign rd_first = (rd_idx == {`CELL_CNT_W{1'b0}});

    // payload storage needs no reset; only the indices and the full and ready flags carry control state
    always @(posedge clk) begin
        if (wr_fire) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // filling stops while a cell is held, so fill and drain never overlap
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_idx <= {`CELL_CNT_W{1'b0}};
            rd_idx <= {`CELL_CNT_W{1'b0}};
            full <= 1'b0;
            wr_ready <= 1'b1;
        end else begin
            if (wr_fire) begin
                if (wr_idx == DEPTH - 1) begin
                    wr_idx <= {`CELL_CNT_W{1'b0}};
                    full <= 1'b1;
                    wr_ready <= 1'b0;
                end else begin
                    wr_idx <= wr_idx + 1'b1;
                end
            end
            if (rd_fire) begin
                if (rd_idx == DEPTH - 1) begin
                    rd_idx <= {`CELL_CNT_W{1'b0}};
                    full <= 1'b0;
                    wr_ready <= 1'b1;
                end else begin
                    rd_idx <= rd_idx + 1'b1;
                end
            end
        end
    end

endmodule
